// ### uof_pkg.sv
/*
  Package for the OTG event flag block: register offset, flag bit positions,
  reset value and timing counts.
  Assumes a 10 MHz system clock.
*/
package uof_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  UOF_FLAGS_OFS   = 8'h00;
  localparam logic [31:0] UOF_FLAGS_RST   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int UOF_BIT_ID      = 7;
  localparam int UOF_BIT_TIMER   = 6;
  localparam int UOF_BIT_LINE    = 5;
  localparam int UOF_BIT_ACTV    = 4;
  localparam int UOF_BIT_SESDROP = 3;
  localparam int UOF_BIT_BVBUS   = 2;
  localparam int UOF_BIT_AVBUS   = 0;
  localparam logic [7:0] UOF_IMPL_MASK = 8'hfd;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 10_000_000;
  localparam int MS_PERIOD_US  = 1000;
  localparam int MS_CYCLES     = (CLK_HZ / 1_000_000) * MS_PERIOD_US;
  localparam logic [13:0] MS_LAST = 14'(MS_CYCLES - 1);

endpackage

// ### uof_event_flags.sv
/*
  OTG event flag register: latches transceiver and comparator events into
  write-one-to-clear flags read over a plain register port, keeps the free
  running 1 ms timer and the line state stability counter that feed two of
  the flags, and mirrors the flag word on a port of its own.
  Assumes transceiver pins are asynchronous to clk_sys; register port is
  synchronous to clk_sys. Pins should sit low through reset: a pin that is
  high then reports one change when the synchronisers first load it.
*/
`timescale 1ns/100ps
module uof_event_flags
  import uof_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Transceiver and comparator inputs
  input  wire logic        id_pin,
  input  wire logic        sess_valid,
  input  wire logic        sess_end,
  input  wire logic        dp_pin,
  input  wire logic        dm_pin,
  input  wire logic        vbus_pin,
  // Flag state
  output logic      [7:0]  otg_event_flags
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Shared by the 1 ms timer and the line stability counter
  function automatic logic [13:0] uof_count_step(
    input logic [13:0] cnt,
    input logic        restart,
    input logic        freeze
  );
    logic [13:0] step;
    step = cnt + 14'h0001;
    if (restart)
      return 14'h0000;
    else if (freeze)
      return cnt;
    else
      return step;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] prev_r;
  logic       primed_r;
  wire  [5:0] pins_raw = {vbus_pin, dm_pin, dp_pin, sess_end, sess_valid, id_pin};

  // Two stages before any logic sees a pin; only stage two fans out
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
    end
  end

  // One-sample history for change detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 6'h00;
    end else begin
      prev_r <= sync2_r;
    end
  end

  // Edge history is unreliable until one sample has been taken after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      primed_r <= 1'b0;
    end else begin
      primed_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  wire [5:0] chg       = primed_r ? (sync2_r ^ prev_r) : 6'h00;
  wire       chg_id    = chg[0];
  wire       chg_valid = chg[1];
  wire       chg_end   = chg[2];
  wire       chg_dp    = chg[3];
  wire       chg_dm    = chg[4];
  wire       chg_vbus  = chg[5];
  // High while the comparator reports VBUS below the session end level
  wire       below_end = sync2_r[2];
  // Comparator moves count as VBUS activity for the wake-up flag
  wire       any_chg   = chg_id | chg_valid | chg_end | chg_dp | chg_dm | chg_vbus;

  // ----------------------------------------------------------------
  // 1 ms timer
  // ----------------------------------------------------------------
  // Free-running from reset; software has no way to restart it
  logic [13:0] ms_cnt_r;
  wire         ms_tick    = (ms_cnt_r == MS_LAST);
  wire  [13:0] ms_cnt_nxt = uof_count_step(ms_cnt_r, ms_tick, 1'b0);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 14'h0000;
    end else begin
      ms_cnt_r <= ms_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Line state stability
  // ----------------------------------------------------------------
  // Line state is the synchronised D+/D- pair; it must hold for a full 1 ms
  logic [1:0]  line_rpt_r;
  logic [13:0] stab_cnt_r;
  logic        stab_done_r;
  wire  [1:0]  line_now      = {sync2_r[4], sync2_r[3]};
  wire         line_moved    = chg_dp | chg_dm;
  wire         stab_full     = (stab_cnt_r == MS_LAST);
  wire         stab_hit      = !line_moved && !stab_done_r && stab_full;
  wire         line_new      = (line_now != line_rpt_r);
  wire         line_evt      = stab_hit && line_new;
  wire         stab_restart  = line_moved || stab_hit;
  // Counter parks after one report until the line moves again
  wire  [13:0] stab_cnt_nxt  = uof_count_step(stab_cnt_r, stab_restart, stab_done_r);
  wire         stab_done_nxt = line_moved ? 1'b0 : (stab_done_r | stab_hit);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stab_cnt_r  <= 14'h0000;
      stab_done_r <= 1'b0;
    end else begin
      stab_cnt_r  <= stab_cnt_nxt;
      stab_done_r <= stab_done_nxt;
    end
  end

  // Last reported stable state; starts as both lines low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_rpt_r <= 2'b00;
    end else if (stab_hit) begin
      line_rpt_r <= line_now;
    end
  end

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  logic [7:0] evt;
  always_comb begin
    evt                  = 8'h00;
    evt[UOF_BIT_ID]      = chg_id;
    evt[UOF_BIT_TIMER]   = ms_tick;
    evt[UOF_BIT_LINE]    = line_evt;
    evt[UOF_BIT_ACTV]    = any_chg;
    evt[UOF_BIT_SESDROP] = chg_end & below_end;
    evt[UOF_BIT_BVBUS]   = chg_end;
    evt[UOF_BIT_AVBUS]   = chg_valid;
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire       hit_flags = (reg_addr == UOF_FLAGS_OFS);
  wire       wr_flags  = reg_wr && hit_flags;
  wire [7:0] clr_mask  = wr_flags ? reg_wdata[7:0] : 8'h00;

  // ----------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------
  logic [7:0] flags_r;
  wire  [7:0] kept      = flags_r & ~clr_mask;
  // Set wins over a clear landing in the same cycle
  wire  [7:0] flags_nxt = (kept | evt) & UOF_IMPL_MASK;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= UOF_FLAGS_RST[7:0];
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Port copy has its own flop so the output comes straight from a register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      otg_event_flags <= UOF_FLAGS_RST[7:0];
    end else begin
      otg_event_flags <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stand for one cycle only; idle cycles read as zero
  wire [31:0] rd_word = hit_flags ? {24'h000000, flags_r & UOF_IMPL_MASK}
                                  : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_word;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ### uof_xcvr_model.sv
/* Transceiver and comparator model for the OTG inputs.
   Assumes the bench asks for pin levels on clk_sys. */
`timescale 1ns/100ps
module uof_xcvr_model (
  input  wire logic       clk_sys,
  input  wire logic [5:0] want,
  output logic      [5:0] pins
);
  // Levels move just after an edge, as a comparator output would
  initial pins = 6'h00;
  always @(posedge clk_sys) pins <= want;
endmodule

// ### uof_event_flags_asserts.sv
/* Checker for the OTG event flags.
   Assumes it is bound to uof_event_flags. */
`timescale 1ns/100ps
module uof_event_flags_asserts
  import uof_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        id_pin,
  input wire logic        sess_valid,
  input wire logic        sess_end,
  input wire logic        dp_pin,
  input wire logic        dm_pin,
  input wire logic        vbus_pin,
  input wire logic [7:0]  otg_event_flags
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [13:0] cnt_r;
  logic [7:0]  held;
  // Flags that no write-one touches this cycle
  assign held = otg_event_flags &
                ((reg_wr && reg_addr == UOF_FLAGS_OFS) ? ~reg_wdata[7:0] : 8'hff);
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      cnt_r <= 14'h0;
    else
      cnt_r <= (cnt_r == MS_LAST) ? 14'h0 : cnt_r + 14'h1;
  chk_read_data: assert property (reg_rdata == (($past(reg_rd) && $past(reg_addr) ==
    UOF_FLAGS_OFS) ? {24'h0, $past(otg_event_flags)} : 32'h0)) else $error("rdata");
  chk_flag_sticky: assert property ((otg_event_flags & $past(held)) == $past(held))
    else $error("sticky");
  chk_id_change: assert property ($changed(id_pin) |-> ##[1:4] otg_event_flags[7])
    else $error("id");
  chk_end_change: assert property ($changed(sess_end) |-> ##[1:4] otg_event_flags[2])
    else $error("end");
  chk_valid_change: assert property ($changed(sess_valid) |-> ##[1:4] otg_event_flags[0])
    else $error("valid");
  chk_session_drop: assert property ($rose(sess_end) |-> ##[1:4] otg_event_flags[3])
    else $error("drop");
  chk_bus_activity: assert property ($changed({id_pin, sess_valid, sess_end, dp_pin, dm_pin,
    vbus_pin}) |-> ##[1:4] otg_event_flags[4]) else $error("actv");
  chk_timer_fire: assert property (cnt_r == MS_LAST |-> ##[0:2] otg_event_flags[6])
    else $error("timer");
  chk_timer_clear: assert property (reg_wr && reg_addr == UOF_FLAGS_OFS && reg_wdata[6] &&
    cnt_r != MS_LAST |=> !otg_event_flags[6]) else $error("clear");
  chk_unused_zero: assert property (!otg_event_flags[1] && reg_rdata[31:8] == 24'h0)
    else $error("unused");
  cover property (otg_event_flags[5]);
  cover property (otg_event_flags[6]);
  cover property (reg_wr && reg_wdata[7:0] == 8'hff);
endmodule
bind uof_event_flags uof_event_flags_asserts i_chk (.*);

// ### uof_event_flags_test.sv
/* Self-checking bench for the OTG event flags.
   Assumes a 10 MHz clock and the transceiver model. */
`timescale 1ns/100ps
module uof_event_flags_test
  import uof_pkg::*;
;
  logic        clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [7:0]  reg_addr = 8'h00, flags;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, exp_q[$];
  logic [5:0]  want = 6'h00, pins;
  // Pins to apply, then flags expected
  logic [15:0] st[7] = '{16'h0190, 16'h051c, 16'h0711, 16'h0314, 16'h0b10, 16'h1b10, 16'h3b10};
  int          n_fail = 0, compares = 0;
  always #50 clk_sys = ~clk_sys;
  uof_xcvr_model i_xcvr (.clk_sys(clk_sys), .want(want), .pins(pins));
  uof_event_flags i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .id_pin(pins[0]), .sess_valid(pins[1]), .sess_end(pins[2]), .dp_pin(pins[3]),
    .dm_pin(pins[4]), .vbus_pin(pins[5]), .otg_event_flags(flags));
  task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
  endtask
  task automatic see_flags(input logic [7:0] e);
    @(negedge clk_sys);
    compares++;
    if (flags !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, flags, e);
    end
  endtask
  task automatic results();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) if (rd_d) begin
    compares++;
    if (reg_rdata !== exp_q[0]) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, reg_rdata, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end
  initial begin
    void'($urandom(63651));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    acc(UOF_FLAGS_OFS, UOF_FLAGS_RST, 0);
    for (int i = 0; i < 7; i++) begin
      want <= st[i][13:8];
      repeat (6) @(posedge clk_sys);
      see_flags(st[i][7:0]);
      acc(UOF_FLAGS_OFS, {24'($urandom), 8'h00}, 1);
      acc(UOF_FLAGS_OFS, {24'h0, st[i][7:0]}, 0);
      acc(UOF_FLAGS_OFS, 32'hff, 1);
      acc(UOF_FLAGS_OFS, 32'h0, 0);
      $display("test %0d done", i);
    end
    // Line settles at {1,1}; the timer has fired once by now
    repeat (10100) @(posedge clk_sys);
    acc(8'h04, 32'hff, 1);
    acc(UOF_FLAGS_OFS, 32'h60, 0);
    acc(8'h04, 32'h0, 0);
    $display("test 7 done");
    // A clear and a fresh ID change land on the same edge
    want <= 6'h3a;
    repeat (2) @(posedge clk_sys);
    acc(UOF_FLAGS_OFS, 32'hff, 1);
    acc(UOF_FLAGS_OFS, 32'h90, 0);
    $display("test 8 done");
    repeat (3) @(posedge clk_sys);
    results();
  end
endmodule
